// ---- pkg/glcc_defs.svh ----
/*
  Register indices, field positions, reset values and source codes for the
  pin, lock-status and clock-configuration block.
  Assumes a 32-bit Wishbone bus whose byte address is four times the index.
*/
`ifndef GLCC_DEFS_SVH
`define GLCC_DEFS_SVH

// Register indices (byte address = index * 4)
`define GLCC_IDX_MCLK_CFG 10'h006
`define GLCC_IDX_LOCK_STATUS 10'h007
`define GLCC_IDX_FUNC_CFG 10'h008
`define GLCC_IDX_LEVEL 10'h009
`define GLCC_IDX_SS_FIRST 10'h00a
`define GLCC_IDX_SS_LAST 10'h00d
`define GLCC_IDX_MISC 10'h387

// Lock status fields
`define GLCC_BIT_A1_NOW 0
`define GLCC_BIT_A1_FLAG 1
`define GLCC_BIT_A1_IE 2
`define GLCC_BIT_A2_NOW 4
`define GLCC_BIT_A2_FLAG 5
`define GLCC_BIT_A2_IE 6

// Clock source / misc fields
`define GLCC_BIT_MISC_MUX 1
`define GLCC_BIT_MISC_OSC 2

// Reset values
`define GLCC_RST_ZERO 8'h00
`define GLCC_RST_MISC 8'h04

// Status source register codes
`define GLCC_SRC_LAST_EXT 3'h4
`define GLCC_SRC_LOCK 3'h5
`define GLCC_SRC_DPLL 3'h6
`define GLCC_SRC_IRQ 3'h7

`endif

// ---- pkg/glcc_pkg.sv ----
/*
  Types shared by the pin, lock-status and clock-configuration block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package glcc_pkg;

  typedef enum logic [1:0] {
    GLCC_FN_INPUT,
    GLCC_FN_FOLLOW,
    GLCC_FN_LOW,
    GLCC_FN_HIGH
  } glcc_func_t;

  typedef struct packed {
    logic output_invert;
    logic open_drain;
    logic [2:0] reg_sel;
    logic [2:0] bit_sel;
  } glcc_ss_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [11:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } glcc_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } glcc_wb_rsp_t;

endpackage

// ---- verilog/glcc_mclk_div.sv ----
/*
  Master clock divider: divides its clock by 2, 3 or 4, or holds low.
  Assumes its clock stands for the second analog loop's output.
*/
`timescale 1ns/1ps
`include "glcc_defs.svh"

module glcc_mclk_div
  import glcc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] code_i,
  output logic div_o
);

  logic [1:0] cnt_q;
  logic div_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_q <= 2'h0;
    else if (cnt_q >= code_i)
      cnt_q <= 2'h0;
    else
      cnt_q <= cnt_q + 2'h1;
  end

  // High for the first half of each period, two of three cycles at code 2; code 0 keeps the output low
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      div_q <= 1'b0;
    else if (code_i == 2'h0)
      div_q <= 1'b0;
    else
      div_q <= (cnt_q <= (code_i >> 1));
  end

  assign div_o = div_q;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence div4_run_s;
    (cnt_q == 2'h0 && code_i == 2'h3) ##1 (code_i == 2'h3) [*4];
  endsequence

  div_off_low_a:
    assert property ((code_i == 2'h0) [*2] |=> !div_o)
      else $error("divider not low while disabled");
  div_four_period_a:
    assert property (div4_run_s |-> cnt_q == 2'h0)
      else $error("divide by four period wrong");

endmodule

// ---- verilog/glcc_pin_ctrl.sv ----
/*
  Drive logic for one general-purpose pin: input, fixed level, or a
  status-following output with invert and open-drain options.
  Assumes registered configuration from the register file.
*/
`timescale 1ns/1ps
`include "glcc_defs.svh"

module glcc_pin_ctrl
  import glcc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input glcc_func_t func_i,
  input glcc_ss_t ss_i,
  input wire logic force_en_i,
  input wire logic force_val_i,
  input wire logic [7:0] lock_status_i,
  input wire logic [39:0] ext_status_i,
  input wire logic dpll_locked_i,
  input wire logic irq_any_i,
  output logic pin_o,
  output logic pin_oe
);

  logic sel_bit;
  logic pin_q;
  logic oe_q;
  logic [5:0] ext_idx;

  assign ext_idx = {ss_i.reg_sel, ss_i.bit_sel};

  // Codes up to 4 pick an external status bit; 5 the lock byte, 6 DPLL lock, 7 the interrupt
  always_comb
  begin
    sel_bit = 1'b0;
    if (ss_i.reg_sel <= `GLCC_SRC_LAST_EXT)
      sel_bit = ext_status_i[ext_idx];
    else if (ss_i.reg_sel == `GLCC_SRC_LOCK)
      sel_bit = lock_status_i[ss_i.bit_sel];
    else if (ss_i.reg_sel == `GLCC_SRC_DPLL)
      sel_bit = dpll_locked_i;
    else
      sel_bit = irq_any_i;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_q <= 1'b0;
      oe_q <= 1'b0;
    end
    else if (force_en_i)
    begin
      pin_q <= force_val_i;
      oe_q <= 1'b1;
    end
    else
    begin
      case (func_i)
        GLCC_FN_INPUT:
        begin
          pin_q <= 1'b0;
          oe_q <= 1'b0;
        end
        GLCC_FN_FOLLOW:
        begin
          pin_q <= sel_bit ^ ss_i.output_invert;
          oe_q <= !ss_i.open_drain || sel_bit;
        end
        GLCC_FN_LOW:
        begin
          pin_q <= 1'b0;
          oe_q <= 1'b1;
        end
        default:
        begin
          pin_q <= 1'b1;
          oe_q <= 1'b1;
        end
      endcase
    end
  end

  assign pin_o = pin_q;
  assign pin_oe = oe_q;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  pin_input_float_a:
    assert property (!force_en_i && func_i == GLCC_FN_INPUT |=> !pin_oe)
      else $error("input pin is driven");
  pin_fixed_a:
    assert property (!force_en_i && func_i == GLCC_FN_HIGH |=> pin_oe && pin_o)
      else $error("high output not driven high");
  pin_follow_a:
    assert property (!force_en_i && func_i == GLCC_FN_FOLLOW && !ss_i.open_drain
                     |=> pin_oe && pin_o == $past(sel_bit ^ ss_i.output_invert))
      else $error("follow output wrong level");
  pin_open_drain_a:
    assert property (!force_en_i && func_i == GLCC_FN_FOLLOW && ss_i.open_drain
                     |=> pin_oe == $past(sel_bit))
      else $error("open drain drives while inactive");

endmodule

// ---- verilog/glcc_top.sv ----
/*
  General-purpose pins, analog loop lock status and master clock
  configuration, reached over a classic Wishbone slave with 32-bit data.
  Assumes lock, switch and status inputs synchronous to REF_CLK, and that
  REF_CLK stands for the second analog loop output feeding the divider.
*/
//
// Contract
// - Divisor code 00 holds output low; 01, 10, 11 divide by 2, 3, 4.
// - Oscillator-keep bit set keeps self-config oscillator on after completion.
// - Source select 0 picks divided loop clock, 1 picks external clock input.
// - Lock-now bits read 1 while locked: bit 4 loop two, bit 0 loop one.
// - Lock change flag sets whenever its lock-now bit changes either way.
// - Change flag clears only on a written 1; writing 0 keeps it.
// - Interrupt raised when a set flag has its enable bit at 1.
// - Pin four becomes switch select when either switch mode input is 1.
// - Function code 00 input, 01 follow, 10 drive low, 11 drive high.
// - Function fields: pin4 bits 7:6 down to pin1 bits 1:0.
// - Level readback shows pins 4..1 in bits 3..0, upper bits zero.
// - Follow output takes the bit chosen by its own status-source register.
// - Invert bit 7: 0 follows the status bit, 1 drives its inverse.
// - Open-drain bit 6: 1 drives only while active, floats otherwise.
// - Source register code 111 makes the pin an interrupt output.
`timescale 1ns/1ps
`include "glcc_defs.svh"

module glcc_top
  import glcc_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST_N,
  input glcc_wb_req_t WB_REQ,
  output glcc_wb_rsp_t WB_RSP,
  input wire logic APLL1_LOCK,
  input wire logic APLL2_LOCK,
  input wire logic DPLL_LOCKED,
  input wire logic [39:0] EXT_STATUS,
  input wire logic EXT_SW_DIGITAL,
  input wire logic EXT_SW_ANALOG,
  input wire logic SWITCH_SEL,
  input wire logic [3:0] GPIO_I,
  output logic [3:0] GPIO_O,
  output logic [3:0] GPIO_OE,
  input wire logic EXT_MCLK_IN,
  output logic MCLK_OUT,
  output logic IRQ,
  input wire logic SELFCFG_DONE,
  output logic SELFCFG_OSC_EN
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release
  logic rst_meta_q;
  logic rst_n_q;

  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave: ack one cycle after the request, writes land on the ack edge
  logic ack_q;
  logic [31:0] dat_q;
  logic [31:0] rd_d;
  logic [9:0] idx;
  logic [7:0] wdat;
  logic wr_fire;
  logic req;

  assign idx = WB_REQ.adr[11:2];
  assign wdat = WB_REQ.dat[7:0];
  assign req = WB_REQ.cyc && WB_REQ.stb;
  assign wr_fire = ack_q && req && WB_REQ.we && WB_REQ.sel[0];

  always_ff @(posedge REF_CLK or negedge rst_n_q)
  begin
    if (!rst_n_q)
      ack_q <= 1'b0;
    else
      ack_q <= req && !ack_q;
  end

  always_ff @(posedge REF_CLK or negedge rst_n_q)
  begin
    if (!rst_n_q)
      dat_q <= 32'h0000_0000;
    else if (req && !ack_q)
      dat_q <= rd_d;
  end

  assign WB_RSP = '{ack: ack_q, dat: dat_q};

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [1:0] mclk_div_q;
  logic [1:0] ie_q;
  logic [1:0] flag_q;
  logic [1:0] flag_d;
  logic [1:0] lock_q;
  logic [1:0] lock_in;
  logic [1:0] lock_clr;
  logic [7:0] func_q;
  glcc_ss_t ss_q [4];
  logic osc_keep_q;
  logic mux_sel_q;
  logic [7:0] lock_byte;
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;

  assign lock_in = {APLL2_LOCK, APLL1_LOCK};

  always_ff @(posedge REF_CLK or negedge rst_n_q)
  begin
    if (!rst_n_q)
      lock_q <= 2'h0;
    else
      lock_q <= lock_in;
  end

  // A change in the clearing cycle wins over the clear
  assign lock_clr[0] = wr_fire && idx == `GLCC_IDX_LOCK_STATUS && wdat[`GLCC_BIT_A1_FLAG];
  assign lock_clr[1] = wr_fire && idx == `GLCC_IDX_LOCK_STATUS && wdat[`GLCC_BIT_A2_FLAG];
  assign flag_d = (flag_q & ~lock_clr) | (lock_in ^ lock_q);

  always_ff @(posedge REF_CLK or negedge rst_n_q)
  begin
    if (!rst_n_q)
      flag_q <= 2'h0;
    else
      flag_q <= flag_d;
  end

  always_ff @(posedge REF_CLK or negedge rst_n_q)
  begin
    if (!rst_n_q)
      ie_q <= 2'h0;
    else if (wr_fire && idx == `GLCC_IDX_LOCK_STATUS)
      ie_q <= {wdat[`GLCC_BIT_A2_IE], wdat[`GLCC_BIT_A1_IE]};
  end

  always_ff @(posedge REF_CLK or negedge rst_n_q)
  begin
    if (!rst_n_q)
      func_q <= `GLCC_RST_ZERO;
    else if (wr_fire && idx == `GLCC_IDX_FUNC_CFG)
      func_q <= wdat;
  end

  always_ff @(posedge REF_CLK or negedge rst_n_q)
  begin
    if (!rst_n_q)
      mclk_div_q <= 2'h0;
    else if (wr_fire && idx == `GLCC_IDX_MCLK_CFG)
      mclk_div_q <= wdat[1:0];
  end

  always_ff @(posedge REF_CLK or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      osc_keep_q <= 1'(`GLCC_RST_MISC >> `GLCC_BIT_MISC_OSC);
      mux_sel_q <= 1'b0;
    end
    else if (wr_fire && idx == `GLCC_IDX_MISC)
    begin
      osc_keep_q <= wdat[`GLCC_BIT_MISC_OSC];
      mux_sel_q <= wdat[`GLCC_BIT_MISC_MUX];
    end
  end

  always_ff @(posedge REF_CLK or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      for (int i = 0; i < 4; i++)
        ss_q[i] <= `GLCC_RST_ZERO;
    end
    else if (wr_fire && idx >= `GLCC_IDX_SS_FIRST && idx <= `GLCC_IDX_SS_LAST)
      ss_q[2'(idx - `GLCC_IDX_SS_FIRST)] <= wdat;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped indices read zero
  assign lock_byte = {1'b0, ie_q[1], flag_q[1], lock_q[1], 1'b0, ie_q[0], flag_q[0], lock_q[0]};

  always_comb
  begin
    rd_d = 32'h0000_0000;
    if (idx == `GLCC_IDX_MCLK_CFG)
      rd_d[1:0] = mclk_div_q;
    else if (idx == `GLCC_IDX_LOCK_STATUS)
      rd_d[7:0] = lock_byte;
    else if (idx == `GLCC_IDX_FUNC_CFG)
      rd_d[7:0] = func_q;
    else if (idx == `GLCC_IDX_LEVEL)
      rd_d[3:0] = sync2_q;
    else if (idx >= `GLCC_IDX_SS_FIRST && idx <= `GLCC_IDX_SS_LAST)
      rd_d[7:0] = ss_q[2'(idx - `GLCC_IDX_SS_FIRST)];
    else if (idx == `GLCC_IDX_MISC)
      rd_d[7:0] = {5'h00, osc_keep_q, mux_sel_q, 1'b0};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt, oscillator keep and pin level synchroniser
  logic irq_any;
  logic irq_q;
  logic osc_q;

  assign irq_any = |(flag_q & ie_q);

  always_ff @(posedge REF_CLK or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      irq_q <= 1'b0;
      osc_q <= 1'b1;
    end
    else
    begin
      irq_q <= irq_any;
      osc_q <= !SELFCFG_DONE || osc_keep_q;
    end
  end

  assign IRQ = irq_q;
  assign SELFCFG_OSC_EN = osc_q;

  // Board pins may change at any time, so they are resynchronised anyway
  always_ff @(posedge REF_CLK or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end
    else
    begin
      sync1_q <= GPIO_I;
      sync2_q <= sync1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins
  logic ext_sw;

  assign ext_sw = EXT_SW_DIGITAL || EXT_SW_ANALOG;

  for (genvar g = 0; g < 4; g++)
  begin : g_pin
    glcc_pin_ctrl u_pin (
      .clk(REF_CLK),
      .rst_n(rst_n_q),
      .func_i(glcc_func_t'(func_q[2*g +: 2])),
      .ss_i(ss_q[g]),
      .force_en_i(g == 3 ? ext_sw : 1'b0),
      .force_val_i(SWITCH_SEL),
      .lock_status_i(lock_byte),
      .ext_status_i(EXT_STATUS),
      .dpll_locked_i(DPLL_LOCKED),
      .irq_any_i(irq_any),
      .pin_o(GPIO_O[g]),
      .pin_oe(GPIO_OE[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Master clock divider and source mux
  logic div_out;
  logic mclk_q;

  glcc_mclk_div u_div (
    .clk(REF_CLK),
    .rst_n(rst_n_q),
    .code_i(mclk_div_q),
    .div_o(div_out)
  );

  // External clock is sampled, so it only passes if well below REF_CLK
  always_ff @(posedge REF_CLK or negedge rst_n_q)
  begin
    if (!rst_n_q)
      mclk_q <= 1'b0;
    else
      mclk_q <= mux_sel_q ? EXT_MCLK_IN : div_out;
  end

  assign MCLK_OUT = mclk_q;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!rst_n_q);

  sequence clear_write_s(int b);
    wr_fire && idx == `GLCC_IDX_LOCK_STATUS && wdat[b];
  endsequence

  flag_set_a:
    assert property (lock_in[0] != lock_q[0] |=> flag_q[0] ##1 flag_q[0] || $past(lock_clr[0]))
      else $error("lock change did not set flag");
  flag_clear_a:
    assert property (clear_write_s(`GLCC_BIT_A2_FLAG) ##0 lock_in[1] == lock_q[1] |=> !flag_q[1])
      else $error("written one did not clear flag");
  flag_keep_a:
    assert property (flag_q[1] && !lock_clr[1] |=> flag_q[1])
      else $error("flag lost without a clear");
  irq_mask_a:
    assert property (flag_q[0] && !ie_q[0] && !(flag_q[1] && ie_q[1]) |=> !IRQ)
      else $error("masked flag raised interrupt");
  irq_raise_a:
    assert property (flag_q[1] && ie_q[1] |=> IRQ)
      else $error("enabled flag gave no interrupt");
  lock_read_a:
    assert property (req && !ack_q && idx == `GLCC_IDX_LOCK_STATUS
                     |=> WB_RSP.ack && WB_RSP.dat[4] == $past(lock_q[1]) && WB_RSP.dat[0] == $past(lock_q[0]))
      else $error("lock read data wrong");
  level_sync_a:
    assert property (##2 sync2_q == $past(GPIO_I, 2))
      else $error("level readback not two stages");
  ext_switch_a:
    assert property (ext_sw |=> GPIO_OE[3] && GPIO_O[3] == $past(SWITCH_SEL))
      else $error("pin four not switch select");
  mux_src_a:
    assert property (!mux_sel_q |=> MCLK_OUT == $past(div_out))
      else $error("master clock source wrong");
  osc_keep_a:
    assert property (SELFCFG_DONE && !osc_keep_q |=> !SELFCFG_OSC_EN)
      else $error("oscillator left on after config");
  ack_pulse_a:
    assert property (req && !ack_q |=> WB_RSP.ack ##1 !WB_RSP.ack)
      else $error("ack not a one cycle answer");

endmodule

// ---- tb/glcc_board.sv ----
/*
  Board logic on the four general-purpose pins: pull-ups plus an optional
  board driver on each pin.
  Gives the device level priority wherever the bench also drives a pin.
*/
`timescale 1ns/1ps

module glcc_board
(
  input wire logic [3:0] pin_o,
  input wire logic [3:0] pin_oe,
  input wire logic [3:0] drv_en,
  input wire logic [3:0] drv_val,
  output logic [3:0] pin_lvl
);
  ////////////////////////////////////////////////////////////////////////
  // A pin nobody drives floats up, so a released open-drain pin reads 1
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      pin_lvl[i] = pin_oe[i] ? pin_o[i] : (drv_en[i] ? drv_val[i] : 1'b1);
    end
  end
endmodule

// ---- tb/tb_glcc_top.sv ----
/*
  Self-checking bench: registers over classic Wishbone, lock flags, pins,
  switch override and master clock, against a small model.
  Assumes the top module and the board model from the bench folder.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, (g), (e)); end end

module tb_glcc_top
  import glcc_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  integer num_errors = 0;
  integer n_tests = 0;
  integer seed = 59;
  glcc_wb_req_t wb_req = '0;
  glcc_wb_rsp_t wb_rsp;
  logic [1:0] lk = 2'b00;
  logic dpll = 1'b0, sw_dig = 1'b0, sw_ana = 1'b0, sw_sel = 1'b0;
  logic ext_mclk = 1'b0, cfg_done = 1'b1;
  logic [39:0] ext_st = '0;
  logic [3:0] gpio_i, gpio_o, gpio_oe;
  logic [3:0] drv_en = 4'hf, drv_val = 4'h0;
  logic mclk_out, irq, osc_en;
  logic [31:0] rdw;
  // Model of the lock flags and their enables
  logic [1:0] m_flag = 2'b00, m_ie = 2'b00;

  glcc_top glcc_top_inst (.REF_CLK(ref_clk), .RST_N(rst_n), .WB_REQ(wb_req), .WB_RSP(wb_rsp),
    .APLL1_LOCK(lk[0]), .APLL2_LOCK(lk[1]), .DPLL_LOCKED(dpll), .EXT_STATUS(ext_st),
    .EXT_SW_DIGITAL(sw_dig), .EXT_SW_ANALOG(sw_ana), .SWITCH_SEL(sw_sel), .GPIO_I(gpio_i),
    .GPIO_O(gpio_o), .GPIO_OE(gpio_oe), .EXT_MCLK_IN(ext_mclk), .MCLK_OUT(mclk_out),
    .IRQ(irq), .SELFCFG_DONE(cfg_done), .SELFCFG_OSC_EN(osc_en));

  glcc_board glcc_board_inst (.pin_o(gpio_o), .pin_oe(gpio_oe), .drv_en(drv_en),
    .drv_val(drv_val), .pin_lvl(gpio_i));

  initial
  begin
    forever #2.5 ref_clk = ~ref_clk;
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus cycles: no fixed latency assumed, the watchdog ends a hang
  task automatic wb(input logic we, input logic [9:0] idx, input logic [7:0] wd);
    @(posedge ref_clk);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {idx, 2'b00}, sel: 4'h1, dat: {24'h0, wd}};
    @(posedge ref_clk);
    while (wb_rsp.ack !== 1'b1) @(posedge ref_clk);
    rdw = wb_rsp.dat;
    wb_req <= '0;
  endtask

  task automatic rd_chk(input logic [9:0] idx, input logic [7:0] e);
    wb(1'b0, idx, 8'h00);
    `CHK(rdw, {24'h0, e})
  endtask

  task automatic wr(input logic [9:0] idx, input logic [7:0] v);
    wb(1'b1, idx, v);
    if (idx == 10'h007)
    begin
      m_ie = {v[6], v[2]};
      m_flag = m_flag & ~{v[5], v[1]};
    end
  endtask

  function automatic logic [7:0] lock_byte();
    return {1'b0, m_ie[1], m_flag[1], lk[1], 1'b0, m_ie[0], m_flag[0], lk[0]};
  endfunction

  task automatic chk_lock();
    repeat (3) @(posedge ref_clk);
    rd_chk(10'h007, lock_byte());
    `CHK(irq, |(m_flag & m_ie))
  endtask

  // Returns {drive enable, drive value} for one pin
  function automatic logic [1:0] pin_exp(input logic [1:0] fn, input logic [7:0] s);
    logic b;
    logic [7:0] lb;
    lb = lock_byte();
    case (s[5:3])
      3'h5: b = lb[s[2:0]];
      3'h6: b = dpll;
      3'h7: b = |(m_flag & m_ie);
      default: b = ext_st[s[5:3] * 8 + s[2:0]];
    endcase
    case (fn)
      2'b00: return 2'b00;
      2'b01: return {s[6] ? b : 1'b1, b ^ s[7]};
      2'b10: return 2'b10;
      default: return 2'b11;
    endcase
  endfunction

  task automatic print_verdict();
    $display("checks=%0d errors=%0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    repeat (5000) @(posedge ref_clk);
    num_errors++;
    print_verdict();
  end

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [9:0] idx_t[10];
    int exp_h[4];
    int h;
    logic [7:0] fc;
    logic [7:0] ss[4];
    logic [1:0] e;
    logic [3:0] lvl;
    logic q0, q1, v;
    idx_t = '{10'h006, 10'h007, 10'h008, 10'h009, 10'h00a, 10'h00b, 10'h00c, 10'h00d,
      10'h387, 10'h100};
    exp_h = '{0, 12, 16, 12};
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    // Reset values, unmapped place ignores writes
    for (int i = 0; i < 10; i++) rd_chk(idx_t[i], idx_t[i] == 10'h387 ? 8'h04 : 8'h00);
    wr(10'h100, 8'hff);
    rd_chk(10'h100, 8'h00);
    `CHK(osc_en, 1'b1)
    // Lock status, flags in both directions, masking and clearing
    lk <= 2'b01; m_flag[0] = 1'b1; chk_lock();
    wr(10'h007, 8'h04); chk_lock();
    lk <= 2'b11; m_flag[1] = 1'b1; chk_lock();
    wr(10'h007, 8'h06); chk_lock();
    lk <= 2'b10; m_flag[0] = 1'b1; chk_lock();
    wr(10'h007, 8'h77); chk_lock();
    lk <= 2'b01; m_flag = 2'b11; chk_lock();
    wr(10'h007, 8'h44); chk_lock();
    // Random pin functions and status sources
    for (int n = 0; n < 24; n++)
    begin
      fc = 8'($random(seed));
      ext_st <= {8'($random(seed)), 32'($random(seed))};
      dpll <= 1'($random(seed));
      drv_en <= 4'($random(seed));
      drv_val <= 4'($random(seed));
      wr(10'h008, fc);
      for (int p = 0; p < 4; p++)
      begin
        ss[p] = 8'($random(seed));
        wr(10'h00a + 10'(p), ss[p]);
      end
      repeat (5) @(posedge ref_clk);
      for (int p = 0; p < 4; p++)
      begin
        e = pin_exp(fc[2 * p +: 2], ss[p]);
        `CHK(gpio_oe[p], e[1])
        if (e[1]) `CHK(gpio_o[p], e[0])
        lvl[p] = e[1] ? e[0] : (drv_en[p] ? drv_val[p] : 1'b1);
      end
      rd_chk(10'h009, {4'h0, lvl});
    end
    // Switch mode takes over pin four from either source
    for (int k = 0; k < 2; k++)
    begin
      sw_dig <= (k == 0);
      sw_ana <= (k == 1);
      sw_sel <= 1'($random(seed));
      repeat (4) @(posedge ref_clk);
      `CHK(gpio_oe[3], 1'b1)
      `CHK(gpio_o[3], sw_sel)
    end
    sw_dig <= 1'b0;
    sw_ana <= 1'b0;
    // Divider duty over a window that holds whole periods of every ratio
    for (int c = 0; c < 4; c++)
    begin
      wr(10'h006, 8'(c));
      repeat (8) @(posedge ref_clk);
      h = 0;
      repeat (24)
      begin
        @(posedge ref_clk);
        // An unknown level must spoil the count, even for the held-low code
        if (mclk_out === 1'b1)
          h++;
        else if (mclk_out !== 1'b0)
          h = h + 100;
      end
      `CHK(h, exp_h[c])
    end
    wr(10'h387, 8'h02);
    repeat (2) @(posedge ref_clk);
    `CHK(osc_en, 1'b0)
    // Oscillator must run again while self-configuration is not complete
    cfg_done <= 1'b0;
    repeat (2) @(posedge ref_clk);
    `CHK(osc_en, 1'b1)
    rd_chk(10'h387, 8'h02);
    q0 = 1'b0;
    q1 = 1'b0;
    repeat (20)
    begin
      @(posedge ref_clk);
      `CHK(mclk_out, q1)
      v = 1'($random(seed));
      q1 = q0;
      q0 = v;
      ext_mclk <= v;
    end
    print_verdict();
  end
endmodule
